// [dv/sms_pin_drv.sv]
// far-side model of the reset, standby and interrupt pin drivers
module sms_pin_drv (
    input wire logic pclk,
    output logic chip_init_pin_n,
    output logic hw_standby_pin_n,
    output logic nmi_pin,
    output logic ext_int_0_pin,
    output logic ext_int_1_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle high, nothing asserted at time zero
    initial begin
        chip_init_pin_n = 1'b1;
        hw_standby_pin_n = 1'b1;
        nmi_pin = 1'b1;
        ext_int_0_pin = 1'b1;
        ext_int_1_pin = 1'b1;
    end
    // one pin changed just after an edge: 0/1 irq, 2 nmi, 3 init, 4 standby
    task automatic pin_set(input int which, input logic lvl);
        @(posedge pclk);
        case (which)
            0: ext_int_0_pin <= lvl;
            1: ext_int_1_pin <= lvl;
            2: nmi_pin <= lvl;
            3: chip_init_pin_n <= lvl;
            default: hw_standby_pin_n <= lvl;
        endcase
    endtask : pin_set
    // mode pins never driven, so constant in standby
    task automatic hw_enter();
        pin_set(3, 1'b0);
        repeat (4) @(posedge pclk);
        pin_set(4, 1'b0);
    endtask : hw_enter
    // init held low while oscillator settles
    task automatic hw_exit(input int hold);
        pin_set(4, 1'b1);
        repeat (hold) @(posedge pclk);
        pin_set(3, 1'b1);
    endtask : hw_exit
endmodule : sms_pin_drv

// [dv/sms_standby_seq_test.sv]
// self-checking bench for the standby mode sequencer
module sms_standby_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sms_pkg::*;
    // short counts keep the run small; expectations use the same table
    // external clock assumed, so any settle and divide choice is allowed
    localparam int unsigned S_TAB [6] = '{8, 16, 32, 64, 128, 4};
    logic pclk, presetn, psel, penable, pwrite, power_down_instr, cpu_int_mask;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ext_int_enable;
    logic pready, pslverr, er, cpu_halt, chip_clk_en, periph_reset, osc_run;
    logic port_hold, port_hiz, int_exc_start, rst_exc_start, ram_enable;
    logic chip_init_pin_n, hw_standby_pin_n, nmi_pin, ext_int_0_pin, ext_int_1_pin;
    int fails = 0;
    int n_checks = 0;
    int seed = 2750;
    int n, src, ex;
    logic [1:0] dv;
    sms_pin_drv i_sms_pin_drv (.pclk(pclk), .chip_init_pin_n(chip_init_pin_n),
        .hw_standby_pin_n(hw_standby_pin_n), .nmi_pin(nmi_pin),
        .ext_int_0_pin(ext_int_0_pin), .ext_int_1_pin(ext_int_1_pin));
    sms_standby_seq #(.SETTLE_CNT_8K(S_TAB[0]), .SETTLE_CNT_16K(S_TAB[1]),
        .SETTLE_CNT_32K(S_TAB[2]), .SETTLE_CNT_64K(S_TAB[3]),
        .SETTLE_CNT_128K(S_TAB[4]), .SETTLE_CNT_1K(S_TAB[5])) i_sms_standby_seq (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down_instr(power_down_instr),
        .chip_init_pin_n(chip_init_pin_n), .hw_standby_pin_n(hw_standby_pin_n),
        .nmi_pin(nmi_pin), .ext_int_0_pin(ext_int_0_pin), .ext_int_1_pin(ext_int_1_pin),
        .ext_int_enable(ext_int_enable), .cpu_int_mask(cpu_int_mask),
        .cpu_halt(cpu_halt), .chip_clk_en(chip_clk_en), .periph_reset(periph_reset),
        .osc_run(osc_run), .port_hold(port_hold), .port_hiz(port_hiz),
        .int_exc_start(int_exc_start), .rst_exc_start(rst_exc_start),
        .ram_enable(ram_enable));
    always #12.5 pclk = ~pclk;
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check
    // waits on pready without assuming its latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) check(0, 1, "apb timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse_pd();
        @(posedge pclk);
        power_down_instr <= 1'b1;
        @(posedge pclk);
        power_down_instr <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
    endtask : pulse_pd
    task automatic enter_sw(input logic [2:0] code, input logic [1:0] d, input logic eg);
        apb(1'b1, OFF_SYSCTL, {24'h0, 1'b1, code, eg, 3'h1});
        apb(1'b1, OFF_DIVCTL, {30'h0, d});
        pulse_pd();
        check({cpu_halt, chip_clk_en, periph_reset, osc_run, port_hold, port_hiz},
            6'b101010, "sw standby outputs");
    endtask : enter_sw
    task automatic wait_pulse(input logic rst, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (((rst ? rst_exc_start : int_exc_start) !== 1'b1) && n < lim);
    endtask : wait_pulse
    function automatic int exp_cyc(input logic [2:0] c, input logic [1:0] d);
        return S_TAB[c] << d;
    endfunction : exp_cyc
    initial begin
        #(25ns * 60000);
        check(0, 1, "watchdog");
        print_verdict();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, power_down_instr, cpu_int_mask} = 7'h0;
        {paddr, pwdata, ext_int_enable} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_SYSCTL, 32'h0);
        check(rd, 32'h00000001, "sysctl reset");
        apb(1'b0, OFF_DIVCTL, 32'h0);
        check(rd, 32'h0, "divctl reset");
        apb(1'b0, OFF_STATUS, 32'h0);
        check(32'(rd[4:0]), 32'h10, "status reset");
        apb(1'b0, 12'hFFC, 32'h0);
        check(er, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, OFF_SYSCTL, 32'h00000069);
        apb(1'b0, OFF_SYSCTL, 32'h0);
        check(rd, 32'h00000009, "illegal settle code kept");
        pulse_pd();
        check(cpu_halt, 1'b0, "sleep select ignored");
        for (int i = 0; i < 8; i++) begin
            src = i % 4;
            dv = 2'($random(seed) & 3);
            if (src == 2) i_sms_pin_drv.pin_set(2, 1'b0);
            enter_sw(3'(i % 6), dv, src == 2);
            repeat ($random(seed) & 7) @(posedge pclk);
            if (src < 2) begin
                i_sms_pin_drv.pin_set(src, 1'b0);
                repeat (6) @(posedge pclk);
                ext_int_enable <= 2'h3;
                cpu_int_mask <= 1'b1;
                repeat (6) @(posedge pclk);
                apb(1'b0, OFF_STATUS, 32'h0);
                check(32'(rd[2:0]), 32'(ST_SWSTBY), "stayed asleep");
                @(posedge pclk);
                cpu_int_mask <= 1'b0;
            end else
                i_sms_pin_drv.pin_set(2, src == 2);
            ex = exp_cyc(3'(i % 6), dv);
            wait_pulse(1'b0, 2000);
            check(n >= ex && n <= ex + 6, 1, "settle length");
            check({cpu_halt, chip_clk_en, periph_reset, osc_run, port_hold},
                5'b01010, "awake outputs");
            i_sms_pin_drv.pin_set(src % 3, 1'b1);
            ext_int_enable <= 2'h0;
            apb(1'b0, OFF_SYSCTL, 32'h0);
            check(rd[BIT_STANDBY_SEL], 1'b1, "standby select kept");
        end
        enter_sw(3'h4, 2'h3, 1'b0);
        i_sms_pin_drv.pin_set(3, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        check({chip_clk_en, osc_run}, 2'b11, "clock at once");
        repeat (20) @(posedge pclk);
        i_sms_pin_drv.pin_set(3, 1'b1);
        wait_pulse(1'b1, 8);
        check(rst_exc_start, 1'b1, "reset handling");
        apb(1'b1, OFF_SYSCTL, 32'h00000080);
        #1;
        check(ram_enable, 1'b0, "ram enable cleared");
        i_sms_pin_drv.hw_enter();
        repeat (3) @(posedge pclk);
        #1;
        check({cpu_halt, periph_reset, port_hiz}, 3'b111, "hw standby");
        apb(1'b1, OFF_SYSCTL, 32'h00000090);
        apb(1'b0, OFF_SYSCTL, 32'h0);
        check(rd, 32'h00000001, "hw standby resets regs");
        i_sms_pin_drv.hw_exit(20);
        wait_pulse(1'b1, 8);
        check({rst_exc_start, port_hiz}, 2'b10, "hw standby exit");
        enter_sw(3'h0, 2'h0, 1'b0);
        i_sms_pin_drv.pin_set(4, 1'b0);
        repeat (3) @(posedge pclk);
        #1;
        check({port_hiz, port_hold}, 2'b10, "sw to hw standby");
        i_sms_pin_drv.pin_set(3, 1'b0);
        i_sms_pin_drv.hw_exit(20);
        wait_pulse(1'b1, 8);
        check(rst_exc_start, 1'b1, "second exit");
        print_verdict();
    end
endmodule : sms_standby_seq_test

// [logic/sms_pkg.sv]
// shared constants and types for the standby mode sequencer
package sms_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CNT_W = 18;
    localparam logic [11:0] OFF_SYSCTL = 12'h000;
    localparam logic [11:0] OFF_DIVCTL = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam int unsigned BIT_STANDBY_SEL = 7;
    localparam int unsigned BIT_STS_HI = 6;
    localparam int unsigned BIT_STS_LO = 4;
    localparam int unsigned BIT_NMIEDGE = 3;
    localparam int unsigned BIT_RAMEN = 0;
    localparam int unsigned BIT_OSC = 4;
    localparam int unsigned BIT_DONE = 5;
    localparam logic [2:0] STS_RESET = 3'h0;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic RAMEN_RESET = 1'b1;
    localparam logic [2:0] STS_8K = 3'h0;
    localparam logic [2:0] STS_16K = 3'h1;
    localparam logic [2:0] STS_32K = 3'h2;
    localparam logic [2:0] STS_64K = 3'h3;
    localparam logic [2:0] STS_128K = 3'h4;
    localparam logic [1:0] STS_ILLEGAL_TOP = 2'h3;
    localparam int unsigned SETTLE_8K = 8192;
    localparam int unsigned SETTLE_16K = 16384;
    localparam int unsigned SETTLE_32K = 32768;
    localparam int unsigned SETTLE_64K = 65536;
    localparam int unsigned SETTLE_128K = 131072;
    localparam int unsigned SETTLE_1K = 1024;
    localparam logic [2:0] DIV_MASK_1 = 3'h0;
    localparam logic [2:0] DIV_MASK_2 = 3'h1;
    localparam logic [2:0] DIV_MASK_4 = 3'h3;
    localparam logic [2:0] DIV_MASK_8 = 3'h7;
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SWSTBY = 3'h1,
        ST_SETTLE = 3'h3,
        ST_RESWAIT = 3'h2,
        ST_HWSTBY = 3'h6
    } sms_state_type;
endpackage : sms_pkg

// [logic/sms_settle_cnt.sv]
// oscillator settling counter on the divided clock enable
module sms_settle_cnt (
    input wire logic pclk,
    input wire logic presetn,
    sms_settle_if.cnt stl
);
    import sms_pkg::*;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;
    logic at_end;

    assign at_end = (cnt_ff == stl.limit - CNT_W'(1));
    assign nxt_cnt = !stl.run ? '0 : (stl.tick && !done_ff && !at_end) ? cnt_ff + CNT_W'(1)
                   : cnt_ff;
    assign nxt_done = stl.run && (done_ff || (stl.tick && at_end));
    assign stl.done = done_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    a_cnt_done_len: assert property (@(posedge pclk) disable iff (!presetn)
        stl.run && stl.tick && !done_ff && at_end |=> done_ff)
        else $error("settle count end not flagged");
    a_cnt_no_early: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_ff) |-> $past(at_end) && $past(stl.tick))
        else $error("settle done raised early");
endmodule : sms_settle_cnt

// [logic/sms_settle_if.sv]
// carrier between the sequencer and its settling counter
interface sms_settle_if;
    import sms_pkg::*;
    logic run;
    logic tick;
    logic [CNT_W-1:0] limit;
    logic done;
    modport ctl (output run, output tick, output limit, input done);
    modport cnt (input run, input tick, input limit, output done);
endinterface : sms_settle_if

// [logic/sms_standby_seq.sv]
// software and hardware standby sequencer with apb control registers
// Operation
// - power-down instruction with standby_select 1 enters software standby
// - software standby halts cpu, clock, peripherals; resets peripherals; keeps registers, ram
// - enabled interrupt wakes: oscillator on, settle, clock on, interrupt handling
// - disabled or masked interrupt request leaves software standby untouched
// - chip_init_pin_n fall clocks chip at once; its rise starts reset handling
// - hw_standby_pin_n low in software standby enters hardware standby
// - settle code selects 8192,16384,32768,65536,131072,1024 states; 11x illegal
// - settling count runs on divided clock, doubling per divide step
// - nmi_edge_select picks nmi edge: 0 falling, 1 rising
// - software standby holds all i/o ports in existing state
// - hw_standby_pin_n low anywhere halts, resets all but ram, tri-states ports
// - standby pin rises with init low; oscillator starts; init rise resets
// - standby_select stays 1 after interrupt wake until software clears it
module sms_standby_seq #(
    parameter int unsigned SETTLE_CNT_8K = sms_pkg::SETTLE_8K,
    parameter int unsigned SETTLE_CNT_16K = sms_pkg::SETTLE_16K,
    parameter int unsigned SETTLE_CNT_32K = sms_pkg::SETTLE_32K,
    parameter int unsigned SETTLE_CNT_64K = sms_pkg::SETTLE_64K,
    parameter int unsigned SETTLE_CNT_128K = sms_pkg::SETTLE_128K,
    parameter int unsigned SETTLE_CNT_1K = sms_pkg::SETTLE_1K
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sms_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_down_instr,
    input wire logic chip_init_pin_n,
    input wire logic hw_standby_pin_n,
    input wire logic nmi_pin,
    input wire logic ext_int_0_pin,
    input wire logic ext_int_1_pin,
    input wire logic [1:0] ext_int_enable,
    input wire logic cpu_int_mask,
    output logic cpu_halt,
    output logic chip_clk_en,
    output logic periph_reset,
    output logic osc_run,
    output logic port_hold,
    output logic port_hiz,
    output logic int_exc_start,
    output logic rst_exc_start,
    output logic ram_enable
);
    import sms_pkg::*;

    // elaboration check: counts must fit the settle counter
    if (SETTLE_CNT_128K >= (1 << CNT_W) || SETTLE_CNT_1K == 0 || SETTLE_CNT_8K == 0 ||
        SETTLE_CNT_16K == 0 || SETTLE_CNT_32K == 0 || SETTLE_CNT_64K == 0 ||
        SETTLE_CNT_128K == 0 || ADDR_W < 4) begin : g_bad_settle
        $error("sms_standby_seq: settle counts must be 1 .. 2**CNT_W-1");
    end

    sms_settle_if stl ();

    sms_state_type state_ff;
    sms_state_type nxt_state;
    logic standby_select_ff;
    logic [2:0] settle_time_select_ff;
    logic nmi_edge_select_ff;
    logic ram_enable_ff;
    logic [1:0] clock_divide_select_ff;
    logic [2:0] div_cnt_ff;
    logic init_prev_ff;
    logic nmi_prev_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic cpu_halt_ff;
    logic chip_clk_en_ff;
    logic periph_reset_ff;
    logic osc_run_ff;
    logic port_hold_ff;
    logic port_hiz_ff;
    logic int_exc_ff;
    logic rst_exc_ff;

    // apb decode
    wire acc = psel && penable;
    wire acc_first = acc && !pready_ff;
    wire acc_done = acc && pready_ff;
    wire hit_sys = (paddr == OFF_SYSCTL[ADDR_W-1:0]);
    wire hit_div = (paddr == OFF_DIVCTL[ADDR_W-1:0]);
    wire hit_sta = (paddr == OFF_STATUS[ADDR_W-1:0]);
    wire mapped = hit_sys || hit_div || hit_sta;
    wire in_hw = (state_ff == ST_HWSTBY);
    wire sys_wr = acc_done && pwrite && hit_sys && !in_hw;
    wire div_wr = acc_done && pwrite && hit_div && !in_hw;
    wire [2:0] wr_sts = pwdata[BIT_STS_HI:BIT_STS_LO];
    // illegal 11x settle code is refused, old code kept
    wire sts_legal = (wr_sts[2:1] != STS_ILLEGAL_TOP);
    wire [2:0] nxt_sts = (sys_wr && sts_legal) ? wr_sts : settle_time_select_ff;

    wire [31:0] sys_rd = {24'h0, standby_select_ff, settle_time_select_ff,
                          nmi_edge_select_ff, 2'h0, ram_enable_ff};
    wire [31:0] div_rd = {30'h0, clock_divide_select_ff};
    wire [31:0] sta_rd = {26'h0, stl.done, osc_run_ff, 1'b0, state_ff};
    wire [31:0] nxt_prdata = hit_sys ? sys_rd : hit_div ? div_rd : hit_sta ? sta_rd : 32'h0;

    // pin events
    wire init_fall = init_prev_ff && !chip_init_pin_n;
    wire init_rise = !init_prev_ff && chip_init_pin_n;
    wire nmi_edge = nmi_edge_select_ff ? (!nmi_prev_ff && nmi_pin) : (nmi_prev_ff && !nmi_pin);
    // irq needs enable and no cpu mask; nmi is never masked
    wire irq_wake = !cpu_int_mask && ((!ext_int_0_pin && ext_int_enable[0]) ||
                                      (!ext_int_1_pin && ext_int_enable[1]));
    wire wake = nmi_edge || irq_wake;

    // divided clock enable, steps double the wait
    wire [2:0] div_mask = (clock_divide_select_ff == 2'h0) ? DIV_MASK_1 :
                          (clock_divide_select_ff == 2'h1) ? DIV_MASK_2 :
                          (clock_divide_select_ff == 2'h2) ? DIV_MASK_4 : DIV_MASK_8;
    // tick on the last cycle of each period, so n ticks span n full divided states
    wire div_tick = osc_run_ff && ((div_cnt_ff & div_mask) == div_mask);

    wire [CNT_W-1:0] settle_limit =
        (settle_time_select_ff == STS_8K) ? CNT_W'(SETTLE_CNT_8K) :
        (settle_time_select_ff == STS_16K) ? CNT_W'(SETTLE_CNT_16K) :
        (settle_time_select_ff == STS_32K) ? CNT_W'(SETTLE_CNT_32K) :
        (settle_time_select_ff == STS_64K) ? CNT_W'(SETTLE_CNT_64K) :
        (settle_time_select_ff == STS_128K) ? CNT_W'(SETTLE_CNT_128K) : CNT_W'(SETTLE_CNT_1K);

    assign stl.run = (state_ff == ST_SETTLE);
    assign stl.tick = div_tick;
    assign stl.limit = settle_limit;

    sms_settle_cnt u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .stl(stl)
    );

    always_comb begin
        nxt_state = state_ff;
        if (!hw_standby_pin_n) begin
            nxt_state = ST_HWSTBY;
        end else begin
            unique case (state_ff)
                ST_RUN: begin
                    if (power_down_instr && standby_select_ff) begin
                        nxt_state = ST_SWSTBY;
                    end
                end
                ST_SWSTBY: begin
                    // init fall takes priority over interrupts
                    if (init_fall) begin
                        nxt_state = ST_RESWAIT;
                    end else if (wake) begin
                        nxt_state = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (init_fall) begin
                        nxt_state = ST_RESWAIT;
                    end else if (stl.done) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_RESWAIT: begin
                    if (init_rise) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_HWSTBY: begin
                    // leave with standby pin high, wait for init rise
                    nxt_state = ST_RESWAIT;
                end
                default: begin
                    nxt_state = ST_HWSTBY;
                end
            endcase
        end
    end

    // output decode from next state so outputs align with state_ff
    wire n_run = (nxt_state == ST_RUN);
    wire n_sw = (nxt_state == ST_SWSTBY);
    wire n_set = (nxt_state == ST_SETTLE);
    wire n_rw = (nxt_state == ST_RESWAIT);
    wire n_hw = (nxt_state == ST_HWSTBY);
    wire nxt_cpu_halt = !n_run;
    wire nxt_periph_reset = !n_run;
    wire nxt_chip_clk_en = n_run || n_rw;
    wire nxt_osc_run = n_run || n_set || n_rw;
    // ports hold during software standby and settling
    wire nxt_port_hold = n_sw || n_set;
    wire nxt_port_hiz = n_hw;
    wire nxt_int_exc = (state_ff == ST_SETTLE) && n_run;
    wire nxt_rst_exc = (state_ff == ST_RESWAIT) && n_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_RUN;
            div_cnt_ff <= 3'h0;
            init_prev_ff <= 1'b1;
            nmi_prev_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            div_cnt_ff <= osc_run_ff ? div_cnt_ff + 3'h1 : 3'h0;
            init_prev_ff <= chip_init_pin_n;
            nmi_prev_ff <= nmi_pin;
        end
    end

    // control registers; cleared while in hardware standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_select_ff <= 1'b0;
            settle_time_select_ff <= STS_RESET;
            nmi_edge_select_ff <= 1'b0;
            ram_enable_ff <= RAMEN_RESET;
            clock_divide_select_ff <= DIV_RESET;
        end else if (in_hw || !hw_standby_pin_n) begin
            standby_select_ff <= 1'b0;
            settle_time_select_ff <= STS_RESET;
            nmi_edge_select_ff <= 1'b0;
            ram_enable_ff <= RAMEN_RESET;
            clock_divide_select_ff <= DIV_RESET;
        end else begin
            // only a software write changes standby_select
            standby_select_ff <= sys_wr ? pwdata[BIT_STANDBY_SEL] : standby_select_ff;
            settle_time_select_ff <= nxt_sts;
            nmi_edge_select_ff <= sys_wr ? pwdata[BIT_NMIEDGE] : nmi_edge_select_ff;
            ram_enable_ff <= sys_wr ? pwdata[BIT_RAMEN] : ram_enable_ff;
            clock_divide_select_ff <= div_wr ? pwdata[1:0] : clock_divide_select_ff;
        end
    end

    // one wait state keeps pready registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= acc_first;
            pslverr_ff <= acc_first && !mapped;
            prdata_ff <= (acc_first && !pwrite) ? nxt_prdata : prdata_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_halt_ff <= 1'b0;
            chip_clk_en_ff <= 1'b1;
            periph_reset_ff <= 1'b0;
            osc_run_ff <= 1'b1;
            port_hold_ff <= 1'b0;
            port_hiz_ff <= 1'b0;
            int_exc_ff <= 1'b0;
            rst_exc_ff <= 1'b0;
        end else begin
            cpu_halt_ff <= nxt_cpu_halt;
            chip_clk_en_ff <= nxt_chip_clk_en;
            periph_reset_ff <= nxt_periph_reset;
            osc_run_ff <= nxt_osc_run;
            port_hold_ff <= nxt_port_hold;
            port_hiz_ff <= nxt_port_hiz;
            int_exc_ff <= nxt_int_exc;
            rst_exc_ff <= nxt_rst_exc;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_halt = cpu_halt_ff;
    assign chip_clk_en = chip_clk_en_ff;
    assign periph_reset = periph_reset_ff;
    assign osc_run = osc_run_ff;
    assign port_hold = port_hold_ff;
    assign port_hiz = port_hiz_ff;
    assign int_exc_start = int_exc_ff;
    assign rst_exc_start = rst_exc_ff;
    assign ram_enable = ram_enable_ff;

    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_swstby_entry: assert property (
        state_ff == ST_RUN && hw_standby_pin_n && power_down_instr && standby_select_ff
        |=> state_ff == ST_SWSTBY && cpu_halt_ff && !chip_clk_en_ff)
        else $error("no software standby entry");
    a_swstby_halt: assert property (
        state_ff == ST_SWSTBY |-> cpu_halt_ff && periph_reset_ff && !osc_run_ff)
        else $error("software standby not halted");
    a_irq_wake: assert property (
        state_ff == ST_SWSTBY && hw_standby_pin_n && !init_fall && wake
        |=> state_ff == ST_SETTLE && osc_run_ff ##1 !chip_clk_en_ff)
        else $error("interrupt did not start settling");
    a_masked_stay: assert property (
        state_ff == ST_SWSTBY && hw_standby_pin_n && !init_fall && !wake
        |=> state_ff == ST_SWSTBY)
        else $error("left software standby without a wake");
    a_init_clock: assert property (
        state_ff == ST_SWSTBY && hw_standby_pin_n && init_fall |=> chip_clk_en_ff && osc_run_ff)
        else $error("init fall did not clock chip");
    a_rst_handling: assert property (
        state_ff == ST_RESWAIT && hw_standby_pin_n && init_rise
        |=> rst_exc_ff && state_ff == ST_RUN ##1 !rst_exc_ff)
        else $error("reset handling not started");
    a_hw_any: assert property (
        !hw_standby_pin_n |=> state_ff == ST_HWSTBY && port_hiz_ff && cpu_halt_ff
        && !standby_select_ff ##0 !port_hold_ff)
        else $error("hardware standby not taken");
    a_port_hold: assert property (
        state_ff == ST_SWSTBY |-> port_hold_ff && !port_hiz_ff)
        else $error("ports not held");
    a_settle_gate: assert property (
        state_ff == ST_SETTLE |-> !chip_clk_en_ff && !int_exc_ff)
        else $error("clock ungated during settle");
    a_settle_end: assert property (
        state_ff == ST_SETTLE && stl.done && hw_standby_pin_n && !init_fall
        |=> int_exc_ff && chip_clk_en_ff && !cpu_halt_ff)
        else $error("no interrupt handling after settle");
    a_select_kept: assert property (
        int_exc_ff |-> standby_select_ff || $past(sys_wr, 1) || $past(sys_wr, 2))
        else $error("standby_select lost on wake");
    a_nmi_rise: assert property (
        state_ff == ST_SWSTBY && nmi_edge_select_ff && !nmi_prev_ff && nmi_pin
        && hw_standby_pin_n && !init_fall |=> state_ff == ST_SETTLE)
        else $error("rising nmi did not wake");
    a_div_tick: assert property (
        state_ff == ST_SETTLE && clock_divide_select_ff == 2'h3 && div_tick
        |=> !div_tick [*7])
        else $error("divide by eight tick too frequent");

    c_sw_irq_wake: cover property (state_ff == ST_SETTLE ##1 state_ff == ST_RUN);
    c_sw_init_exit: cover property (state_ff == ST_SWSTBY ##1 state_ff == ST_RESWAIT);
    c_hw_exit: cover property (state_ff == ST_HWSTBY ##1 state_ff == ST_RESWAIT);
    c_apb_write: cover property (sys_wr && pwdata[BIT_STANDBY_SEL]);
endmodule : sms_standby_seq
